// [core/async_timer.sv]
`timescale 1ns/1ps
module async_timer (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire async_timer_pkg::reg_req_t req_in,
  input wire logic crystal_in_pin_in,
  output logic [7:0] rdata_out,
  output async_timer_pkg::wave_pins_t pins_out
);

  // Control and data registers
  logic [7:0] ctrl_a_r; // Compare output modes, low waveform bits
  logic ctrl_b_waveform_mode_r; // Waveform mode bit2
  logic [2:0] clk_sel_r; // Clock prescale select
  logic async_sel_r; // Async clock select
  logic [7:0] cnt_r; // Timer count
  logic up_r; // Count direction in phase-correct mode
  logic block_r; // Suppress match after a count write
  logic [7:0] cmp_a_buf_r; // Compare A as written by software
  logic [7:0] cmp_b_buf_r; // Compare B as written by software
  logic [7:0] cmp_a_act_r; // Compare A in use by the comparator
  logic [7:0] cmp_b_act_r; // Compare B in use by the comparator
  logic ovf_r; // Sticky overflow flag
  logic wave_a_r; // Output latch A
  logic wave_b_r; // Output latch B
  logic [7:0] rdata_r; // Read data, one cycle after the strobe

  // Crystal pin synchroniser and edge finder
  logic xtal_s1_r;
  logic xtal_s2_r;
  logic xtal_s3_r;

  // Prescaler
  logic [async_timer_pkg::PRESC_W-1:0] presc_r;

  // Decoded controls and events
  logic [2:0] wgm;
  async_timer_pkg::mode_cls_t cls;
  logic [1:0] com_a;
  logic [1:0] com_b;
  logic src_tick;
  logic tick;
  logic [7:0] top;
  logic top_evt;
  logic match_a;
  logic match_b;
  logic ovf_set;
  logic wr_hit_ctrl_a;
  logic wr_hit_ctrl_b;
  logic wr_hit_count;
  logic wr_hit_cmp_a;
  logic wr_hit_cmp_b;
  logic wr_hit_async;
  logic wr_hit_flag;
  logic wr_hit_gen;
  logic psr_strobe;

  // Prescaled tap for a clock select code
  function automatic logic presc_tap(
    input logic [2:0] sel,
    input logic [async_timer_pkg::PRESC_W-1:0] pc,
    input logic src
  );
    logic t;
    t = 1'b0;
    case (sel)
      async_timer_pkg::CS_STOP: t = 1'b0;
      async_timer_pkg::CS_DIV1: t = src;
      async_timer_pkg::CS_DIV8: t = src && (&pc[2:0]);
      async_timer_pkg::CS_DIV32: t = src && (&pc[4:0]);
      async_timer_pkg::CS_DIV64: t = src && (&pc[5:0]);
      async_timer_pkg::CS_DIV128: t = src && (&pc[6:0]);
      async_timer_pkg::CS_DIV256: t = src && (&pc[7:0]);
      async_timer_pkg::CS_DIV1024: t = src && (&pc[9:0]);
      default: t = 1'b0;
    endcase
    return t;
  endfunction

  // Next level of an output latch for one channel
  function automatic logic wave_next(
    input logic cur,
    input async_timer_pkg::mode_cls_t mc,
    input logic [1:0] com,
    input logic chan_a,
    input logic waveform_mode,
    input logic match,
    input logic up,
    input logic tevt,
    input logic cmp_is_top
  );
    logic res;
    logic special;
    res = cur;
    special = com[1] && cmp_is_top;
    case (mc)
      async_timer_pkg::CLS_FAST: begin
        if (com == 2'b01) begin
          // Toggle only on channel A with bit2 set
          if (chan_a && waveform_mode && match) begin
            res = ~cur;
          end
        end else if (com[1]) begin
          // Match acts unless compare sits at TOP
          if (match && !special) begin
            res = com[0];
          end
          // BOTTOM follows TOP: set for 10, clear for 11
          if (tevt) begin
            res = ~com[0];
          end
        end
      end
      async_timer_pkg::CLS_PHASE: begin
        if (com == 2'b01) begin
          if (chan_a && waveform_mode && match) begin
            res = ~cur;
          end
        end else if (com[1]) begin
          if (special) begin
            // Match ignored, level set for 10 or cleared for 11 at TOP instead
            if (tevt) begin
              res = ~com[0];
            end
          end else if (match) begin
            res = up ? com[0] : ~com[0];
          end
        end
      end
      default: begin
        // Normal, clear-on-match and reserved modes
        if (match) begin
          case (com)
            2'b01: res = ~cur;
            2'b10: res = 1'b0;
            2'b11: res = 1'b1;
            default: res = cur;
          endcase
        end
      end
    endcase
    return res;
  endfunction

  // Address decode of write strobes
  always_comb begin
    wr_hit_ctrl_a = req_in.wr && (req_in.addr == async_timer_pkg::CTRL_A_OFS);
    wr_hit_ctrl_b = req_in.wr && (req_in.addr == async_timer_pkg::CTRL_B_OFS);
    wr_hit_count = req_in.wr && (req_in.addr == async_timer_pkg::COUNT_OFS);
    wr_hit_cmp_a = req_in.wr && (req_in.addr == async_timer_pkg::CMP_A_OFS);
    wr_hit_cmp_b = req_in.wr && (req_in.addr == async_timer_pkg::CMP_B_OFS);
    wr_hit_async = req_in.wr &&
                   (req_in.addr == async_timer_pkg::ASYNC_STATUS_OFS);
    wr_hit_flag = req_in.wr && (req_in.addr == async_timer_pkg::FLAG_OFS);
    wr_hit_gen = req_in.wr && (req_in.addr == async_timer_pkg::GEN_CTRL_OFS);
    psr_strobe = wr_hit_gen && req_in.wdata[async_timer_pkg::PSR_POS];
  end

  // Mode decode, TOP source and timer events
  always_comb begin
    wgm = {ctrl_b_waveform_mode_r, ctrl_a_r[async_timer_pkg::WGM_LO_HI:0]};
    com_a = ctrl_a_r[async_timer_pkg::COM_A_HI:async_timer_pkg::COM_A_LO];
    com_b = ctrl_a_r[async_timer_pkg::COM_B_HI:async_timer_pkg::COM_B_LO];
    // Counting class and TOP source per mode
    case (wgm)
      async_timer_pkg::WGM_NORMAL: begin
        cls = async_timer_pkg::CLS_NORMAL;
        top = async_timer_pkg::CNT_MAX;
      end
      async_timer_pkg::WGM_PHASE_FF: begin
        cls = async_timer_pkg::CLS_PHASE;
        top = async_timer_pkg::CNT_MAX;
      end
      async_timer_pkg::WGM_CLEAR_ON_MATCH: begin
        cls = async_timer_pkg::CLS_CTC;
        top = cmp_a_act_r;
      end
      async_timer_pkg::WGM_FAST_FF: begin
        cls = async_timer_pkg::CLS_FAST;
        top = async_timer_pkg::CNT_MAX;
      end
      async_timer_pkg::WGM_PHASE_CMP: begin
        cls = async_timer_pkg::CLS_PHASE;
        top = cmp_a_act_r;
      end
      async_timer_pkg::WGM_FAST_CMP: begin
        cls = async_timer_pkg::CLS_FAST;
        top = cmp_a_act_r;
      end
      default: begin
        // Reserved codes count as plain normal mode
        cls = async_timer_pkg::CLS_RESERVED;
        top = async_timer_pkg::CNT_MAX;
      end
    endcase
    // Source clock: every cycle, or a crystal rising edge
    src_tick = async_sel_r ? (xtal_s2_r && !xtal_s3_r) : 1'b1;
    tick = presc_tap(clk_sel_r, presc_r, src_tick);
    // Compare matches, suppressed once after a count write
    match_a = tick && !block_r && (cnt_r == cmp_a_act_r);
    match_b = tick && !block_r && (cnt_r == cmp_b_act_r);
    // TOP reached: wrap in fast PWM, turn in phase-correct
    top_evt = tick && (cnt_r == top) &&
              ((cls != async_timer_pkg::CLS_PHASE) || up_r);
    // Overflow flag points per mode
    case (wgm)
      async_timer_pkg::WGM_PHASE_FF,
      async_timer_pkg::WGM_PHASE_CMP: begin
        ovf_set = tick && !up_r &&
                  (cnt_r == async_timer_pkg::CNT_BOTTOM);
      end
      async_timer_pkg::WGM_FAST_CMP: begin
        ovf_set = top_evt;
      end
      default: begin
        ovf_set = tick && (cnt_r == async_timer_pkg::CNT_MAX);
      end
    endcase
  end

  // Crystal pin synchroniser, first stage read only by the second
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      xtal_s1_r <= 1'b0;
      xtal_s2_r <= 1'b0;
      xtal_s3_r <= 1'b0;
    end else if (ce_in) begin
      xtal_s1_r <= crystal_in_pin_in;
      xtal_s2_r <= xtal_s1_r;
      xtal_s3_r <= xtal_s2_r;
    end
  end

  // Prescaler counts source ticks; software reset restarts it
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      presc_r <= '0;
    end else if (ce_in) begin
      if (psr_strobe) begin
        presc_r <= '0;
      end else if (src_tick) begin
        presc_r <= presc_r + 1'b1;
      end
    end
  end

  // Control registers
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      ctrl_a_r <= async_timer_pkg::CTRL_A_RST;
      ctrl_b_waveform_mode_r <= async_timer_pkg::CTRL_B_RST[async_timer_pkg::WAVEFORM_MODE_POS];
      clk_sel_r <= async_timer_pkg::CTRL_B_RST[async_timer_pkg::CS_HI:0];
      async_sel_r <= 1'b0;
    end else if (ce_in) begin
      if (wr_hit_ctrl_a) begin
        // Bits 3:2 are not implemented
        ctrl_a_r <= req_in.wdata & 8'hf3;
      end
      if (wr_hit_ctrl_b) begin
        ctrl_b_waveform_mode_r <= req_in.wdata[async_timer_pkg::WAVEFORM_MODE_POS];
        clk_sel_r <= req_in.wdata[async_timer_pkg::CS_HI:0];
      end
      if (wr_hit_async) begin
        async_sel_r <= req_in.wdata[async_timer_pkg::ASYNC_SEL_POS];
      end
    end
  end

  // Compare registers: buffered value and value in use
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      cmp_a_buf_r <= async_timer_pkg::CMP_RST;
      cmp_b_buf_r <= async_timer_pkg::CMP_RST;
      cmp_a_act_r <= async_timer_pkg::CMP_RST;
      cmp_b_act_r <= async_timer_pkg::CMP_RST;
    end else if (ce_in) begin
      if (wr_hit_cmp_a) begin
        cmp_a_buf_r <= req_in.wdata;
      end
      if (wr_hit_cmp_b) begin
        cmp_b_buf_r <= req_in.wdata;
      end
      // PWM modes take the new value at the TOP event only
      if ((cls != async_timer_pkg::CLS_PHASE &&
           cls != async_timer_pkg::CLS_FAST) || top_evt) begin
        cmp_a_act_r <= cmp_a_buf_r;
        cmp_b_act_r <= cmp_b_buf_r;
      end
    end
  end

  // Counter and direction
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      cnt_r <= async_timer_pkg::COUNT_RST;
      up_r <= 1'b1;
      block_r <= 1'b0;
    end else if (ce_in) begin
      if (wr_hit_count) begin
        // Software write wins and masks the next match
        cnt_r <= req_in.wdata;
        block_r <= 1'b1;
      end else if (tick) begin
        block_r <= 1'b0;
        case (cls)
          async_timer_pkg::CLS_PHASE: begin
            if (up_r) begin
              if (cnt_r >= top) begin
                up_r <= 1'b0;
                cnt_r <= (top == async_timer_pkg::CNT_BOTTOM) ?
                         cnt_r : cnt_r - 8'h01;
              end else begin
                cnt_r <= cnt_r + 8'h01;
              end
            end else if (cnt_r == async_timer_pkg::CNT_BOTTOM) begin
              up_r <= 1'b1;
              cnt_r <= cnt_r + 8'h01;
            end else begin
              cnt_r <= cnt_r - 8'h01;
            end
          end
          async_timer_pkg::CLS_FAST,
          async_timer_pkg::CLS_CTC: begin
            // Wrap to BOTTOM after TOP
            up_r <= 1'b1;
            cnt_r <= (cnt_r == top) ? async_timer_pkg::CNT_BOTTOM :
                     cnt_r + 8'h01;
          end
          default: begin
            up_r <= 1'b1;
            cnt_r <= cnt_r + 8'h01;
          end
        endcase
      end
    end
  end

  // Overflow flag: set wins over a write-one clear
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      ovf_r <= 1'b0;
    end else if (ce_in) begin
      if (ovf_set) begin
        ovf_r <= 1'b1;
      end else if (wr_hit_flag && req_in.wdata[async_timer_pkg::OVF_POS]) begin
        ovf_r <= 1'b0;
      end
    end
  end

  // Output latches updated by compare and TOP events
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      wave_a_r <= 1'b0;
      wave_b_r <= 1'b0;
    end else if (ce_in) begin
      wave_a_r <= wave_next(wave_a_r, cls, com_a, 1'b1, ctrl_b_waveform_mode_r,
                            match_a, up_r, top_evt,
                            cmp_a_act_r == top);
      wave_b_r <= wave_next(wave_b_r, cls, com_b, 1'b0, ctrl_b_waveform_mode_r,
                            match_b, up_r, top_evt,
                            cmp_b_act_r == top);
    end
  end

  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      rdata_r <= 8'h00;
    end else if (ce_in) begin
      if (req_in.rd) begin
        case (req_in.addr)
          async_timer_pkg::CTRL_A_OFS: rdata_r <= ctrl_a_r;
          async_timer_pkg::CTRL_B_OFS: begin
            // Force bits are not kept and read as zero
            rdata_r <= {4'h0, ctrl_b_waveform_mode_r, clk_sel_r};
          end
          async_timer_pkg::COUNT_OFS: rdata_r <= cnt_r;
          async_timer_pkg::CMP_A_OFS: rdata_r <= cmp_a_buf_r;
          async_timer_pkg::CMP_B_OFS: rdata_r <= cmp_b_buf_r;
          async_timer_pkg::ASYNC_STATUS_OFS: rdata_r <= {7'h00, async_sel_r};
          async_timer_pkg::FLAG_OFS: rdata_r <= {7'h00, ovf_r};
          default: rdata_r <= 8'h00; // Unmapped and strobe-only
        endcase
      end else begin
        rdata_r <= 8'h00;
      end
    end
  end

  // Pin outputs
  always_comb begin
    rdata_out = rdata_r;
    pins_out.wave_a_level = wave_a_r;
    pins_out.wave_a_connect = |com_a;
    pins_out.wave_b_level = wave_b_r;
    pins_out.wave_b_connect = |com_b;
    pins_out.crystal_pins_detach = async_sel_r;
  end

endmodule

// [core/async_timer_pkg.sv]
package async_timer_pkg;

  // Register addresses on the plain register port
  localparam logic [7:0] CTRL_A_OFS = 8'hb0;
  localparam logic [7:0] CTRL_B_OFS = 8'hb1;
  localparam logic [7:0] COUNT_OFS = 8'hb2;
  localparam logic [7:0] CMP_A_OFS = 8'hb3;
  localparam logic [7:0] CMP_B_OFS = 8'hb4;
  localparam logic [7:0] ASYNC_STATUS_OFS = 8'hb6;
  localparam logic [7:0] FLAG_OFS = 8'hb7;
  localparam logic [7:0] GEN_CTRL_OFS = 8'h43;

  // Field positions
  localparam int COM_A_HI = 7;
  localparam int COM_A_LO = 6;
  localparam int COM_B_HI = 5;
  localparam int COM_B_LO = 4;
  localparam int WGM_LO_HI = 1;
  localparam int WAVEFORM_MODE_POS = 3;
  localparam int CS_HI = 2;
  localparam int ASYNC_SEL_POS = 0;
  localparam int PSR_POS = 1;
  localparam int OVF_POS = 0;

  // Reset values
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] CMP_RST = 8'h00;

  // Counter limits
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;

  // Prescaler width and clock select codes
  localparam int PRESC_W = 10;
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV32 = 3'h3;
  localparam logic [2:0] CS_DIV64 = 3'h4;
  localparam logic [2:0] CS_DIV128 = 3'h5;
  localparam logic [2:0] CS_DIV256 = 3'h6;
  localparam logic [2:0] CS_DIV1024 = 3'h7;

  // Waveform mode codes
  localparam logic [2:0] WGM_NORMAL = 3'h0;
  localparam logic [2:0] WGM_PHASE_FF = 3'h1;
  localparam logic [2:0] WGM_CLEAR_ON_MATCH = 3'h2;
  localparam logic [2:0] WGM_FAST_FF = 3'h3;
  localparam logic [2:0] WGM_PHASE_CMP = 3'h5;
  localparam logic [2:0] WGM_FAST_CMP = 3'h7;

  // Counting classes decoded from the waveform mode
  typedef enum logic [2:0] {
    CLS_NORMAL, CLS_CTC, CLS_PHASE, CLS_FAST, CLS_RESERVED
  } mode_cls_t;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // Pin-facing outputs
  typedef struct packed {
    logic wave_a_level;
    logic wave_a_connect;
    logic wave_b_level;
    logic wave_b_connect;
    logic crystal_pins_detach;
  } wave_pins_t;

endpackage

// [tb/async_timer_assertions.sv]
`timescale 1ns/1ps
// Checks the register side effects and waveform pins of the timer
module async_timer_assertions (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire async_timer_pkg::reg_req_t req_in,
  input wire logic crystal_in_pin_in,
  input wire logic [7:0] rdata_out,
  input wire async_timer_pkg::wave_pins_t pins_out
);
  logic wr_q; // Write taken this cycle
  logic rd_q; // Read taken this cycle
  logic [7:0] ad; // Request address
  logic [7:0] ctl_a_r; // Mirror of control A
  logic [2:0] sel_r; // Mirror of the clock select field
  assign wr_q = ce_in && req_in.wr;
  assign rd_q = ce_in && req_in.rd;
  assign ad = req_in.addr;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);

  // Mirrors control A from taken writes
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      ctl_a_r <= 8'h00;
    end else if (wr_q && ad == async_timer_pkg::CTRL_A_OFS) begin
      ctl_a_r <= req_in.wdata;
    end
  end

  // Mirrors the clock select field from taken writes
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      sel_r <= 3'h0;
    end else if (wr_q && ad == async_timer_pkg::CTRL_B_OFS) begin
      sel_r <= req_in.wdata[2:0];
    end
  end

  conn_a_a: assert property (
    wr_q && ad == async_timer_pkg::CTRL_A_OFS
    |=> pins_out.wave_a_connect == (|$past(req_in.wdata[7:6])))
    else $error("output A connect wrong after write");
  conn_b_a: assert property (
    wr_q && ad == async_timer_pkg::CTRL_A_OFS
    |=> pins_out.wave_b_connect == (|$past(req_in.wdata[5:4])))
    else $error("output B connect wrong after write");
  detach_a: assert property (
    wr_q && ad == async_timer_pkg::ASYNC_STATUS_OFS
    |=> pins_out.crystal_pins_detach == $past(req_in.wdata[0]))
    else $error("crystal pin detach wrong after write");
  status_read_a: assert property (
    rd_q && ad == async_timer_pkg::ASYNC_STATUS_OFS
    |=> rdata_out == {7'h00, pins_out.crystal_pins_detach})
    else $error("async select read back wrong");
  gen_read_a: assert property (
    rd_q && ad == async_timer_pkg::GEN_CTRL_OFS |=> rdata_out == 8'h00)
    else $error("prescaler reset bit not read as zero");
  stop_hold_a: assert property (
    sel_r == 3'h0 && $past(sel_r) == 3'h0 && $past(sel_r, 2) == 3'h0
    |=> $stable(pins_out.wave_a_level) && $stable(pins_out.wave_b_level))
    else $error("output level moved while stopped");
  set_a_no_fall_a: assert property (
    !ctl_a_r[0] && ctl_a_r[7:6] == 2'b11 |=> !$fell(pins_out.wave_a_level))
    else $error("output A fell in set mode");
  clr_b_no_rise_a: assert property (
    !ctl_a_r[0] && ctl_a_r[5:4] == 2'b10 |=> !$rose(pins_out.wave_b_level))
    else $error("output B rose in clear mode");
  resv_b_hold_a: assert property (
    ctl_a_r[0] && ctl_a_r[5:4] == 2'b01 |=> $stable(pins_out.wave_b_level))
    else $error("output B moved in reserved PWM setting");

  // Main scenarios seen
  cover property ($changed(pins_out.wave_a_level));
  cover property ($rose(pins_out.crystal_pins_detach));
  cover property ($rose(pins_out.wave_b_connect));
endmodule

bind async_timer async_timer_assertions chk (
  .mclk_in(mclk_in), .nrst_in(nrst_in), .ce_in(ce_in), .req_in(req_in),
  .crystal_in_pin_in(crystal_in_pin_in), .rdata_out(rdata_out),
  .pins_out(pins_out));

// [tb/async_timer_bench.sv]
`timescale 1ns/1ps
// Self-checking bench for the timer registers and waveform pins
module async_timer_bench;
  logic mclk_in = 1'b0; // 40 MHz clock
  logic nrst_in = 1'b0; // Synchronous reset, active low
  logic ce_in = 1'b1; // Clock enable, kept on
  async_timer_pkg::reg_req_t req_in = '0; // Register request
  logic crystal_pin = 1'b0; // Crystal pin level
  logic [7:0] rdata_out; // Read data
  async_timer_pkg::wave_pins_t pins_out; // Waveform pins
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0; // Cycle count for the hang limit
  logic [7:0] d; // Last read data
  int hi_a, hi_b, ch_a, ch_b; // High cycles and level changes

  async_timer dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .ce_in(ce_in),
    .req_in(req_in), .crystal_in_pin_in(crystal_pin),
    .rdata_out(rdata_out), .pins_out(pins_out));

  always #12.5 mclk_in = ~mclk_in;

  // Cuts a hang short
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      results();
    end
  end

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk_in);
    req_in <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_in);
    req_in.wr <= 1'b0;
  endtask

  // One-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [7:0] a);
    @(posedge mclk_in);
    req_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_in);
    req_in.rd <= 1'b0;
    #1 d = rdata_out;
  endtask

  // Compares register and pin values
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Compares measured counts
  task automatic chk_n(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    chk8(d, exp);
  endtask

  // Sets a mode, lets it settle, then measures both pins over a window
  task automatic run(input logic [7:0] ca, cb, pa, pb, input int win);
    logic la;
    logic lb;
    wr(async_timer_pkg::CMP_A_OFS, pa);
    wr(async_timer_pkg::CMP_B_OFS, pb);
    wr(async_timer_pkg::CTRL_A_OFS, ca);
    wr(async_timer_pkg::CTRL_B_OFS, cb);
    #1 chk8({7'h0, pins_out.wave_a_connect}, {7'h0, |ca[7:6]});
    chk8({7'h0, pins_out.wave_b_connect}, {7'h0, |ca[5:4]});
    repeat (600) @(posedge mclk_in);
    {hi_a, hi_b, ch_a, ch_b} = '0;
    @(negedge mclk_in);
    la = pins_out.wave_a_level;
    lb = pins_out.wave_b_level;
    for (int i = 0; i < win; i++) begin
      @(negedge mclk_in);
      hi_a += int'(pins_out.wave_a_level);
      hi_b += int'(pins_out.wave_b_level);
      ch_a += int'(pins_out.wave_a_level != la);
      ch_b += int'(pins_out.wave_b_level != lb);
      la = pins_out.wave_a_level;
      lb = pins_out.wave_b_level;
    end
  endtask

  // Reset values, read-only bits and an unmapped place
  task automatic t_regs;
    rdchk(async_timer_pkg::CTRL_A_OFS, 8'h00);
    rdchk(async_timer_pkg::CTRL_B_OFS, 8'h00);
    rdchk(async_timer_pkg::ASYNC_STATUS_OFS, 8'h00);
    rdchk(8'h55, 8'h00);
    wr(async_timer_pkg::CTRL_A_OFS, 8'hff);
    rdchk(async_timer_pkg::CTRL_A_OFS, 8'hf3);
    wr(async_timer_pkg::CTRL_B_OFS, 8'hf8);
    rdchk(async_timer_pkg::CTRL_B_OFS, 8'h08);
    wr(async_timer_pkg::GEN_CTRL_OFS, 8'h02);
    rdchk(async_timer_pkg::GEN_CTRL_OFS, 8'h00);
    $display("test regs done");
  endtask

  // Each divider from 8 to 1024 after a prescaler reset, then the stopped code
  task automatic t_presc;
    int dv [7] = '{1, 8, 32, 64, 128, 256, 1024};
    for (int c = 2; c < 8; c++) begin
      wr(async_timer_pkg::CTRL_B_OFS, 8'h00);
      wr(async_timer_pkg::COUNT_OFS, 8'h00);
      wr(async_timer_pkg::GEN_CTRL_OFS, 8'h02);
      wr(async_timer_pkg::CTRL_B_OFS, 8'(c));
      repeat (3 * dv[c-1] + dv[c-1] / 2) @(posedge mclk_in);
      rdchk(async_timer_pkg::COUNT_OFS, 8'h03);
    end
    wr(async_timer_pkg::CTRL_B_OFS, 8'h00);
    wr(async_timer_pkg::COUNT_OFS, 8'h07);
    repeat (40) @(posedge mclk_in);
    rdchk(async_timer_pkg::COUNT_OFS, 8'h07);
    $display("test prescaler done");
  endtask

  // Counting from the crystal pin with the pins detached
  task automatic t_async;
    wr(async_timer_pkg::ASYNC_STATUS_OFS, 8'h01);
    #1 chk8({7'h0, pins_out.crystal_pins_detach}, 8'h01);
    rdchk(async_timer_pkg::ASYNC_STATUS_OFS, 8'h01);
    wr(async_timer_pkg::CTRL_A_OFS, 8'h00);
    wr(async_timer_pkg::COUNT_OFS, 8'h00);
    wr(async_timer_pkg::CTRL_B_OFS, 8'h01);
    repeat (5) begin
      repeat (8) @(posedge mclk_in);
      crystal_pin <= 1'b1;
      repeat (8) @(posedge mclk_in);
      crystal_pin <= 1'b0;
    end
    repeat (8) @(posedge mclk_in);
    rdchk(async_timer_pkg::COUNT_OFS, 8'h05);
    wr(async_timer_pkg::ASYNC_STATUS_OFS, 8'h00);
    #1 chk8({7'h0, pins_out.crystal_pins_detach}, 8'h00);
    $display("test async done");
  endtask

  // Overflow flag set at MAX in normal mode, cleared by writing one
  task automatic t_flag;
    wr(async_timer_pkg::CTRL_B_OFS, 8'h01);
    repeat (300) @(posedge mclk_in);
    wr(async_timer_pkg::CTRL_B_OFS, 8'h00);
    rd(async_timer_pkg::FLAG_OFS);
    chk8({7'h0, d[0]}, 8'h01);
    wr(async_timer_pkg::FLAG_OFS, 8'h01);
    rd(async_timer_pkg::FLAG_OFS);
    chk8({7'h0, d[0]}, 8'h00);
    $display("test flag done");
  endtask

  // Every waveform mode with its output actions
  task automatic t_wave;
    run(8'h50, 8'h01, 8'h02, 8'h05, 256);
    chk_n(ch_a, 1);
    chk_n(ch_b, 1);
    run(8'he0, 8'h01, 8'h02, 8'h05, 256);
    chk_n(hi_a, 256);
    chk_n(hi_b, 0);
    run(8'h52, 8'h01, 8'h09, 8'h03, 100);
    chk_n(ch_a, 10);
    chk_n(ch_b, 10);
    run(8'hb3, 8'h01, 8'h40, 8'h40, 256);
    chk_n(hi_a, 65);
    chk_n(hi_b, 191);
    run(8'h53, 8'h01, 8'h40, 8'h40, 256);
    chk_n(ch_a, 0);
    chk_n(ch_b, 0);
    run(8'h63, 8'h09, 8'h3f, 8'h10, 256);
    chk_n(ch_a, 4);
    chk_n(hi_b, 68);
    run(8'hb3, 8'h09, 8'h3f, 8'h3f, 256);
    chk_n(hi_a, 256);
    chk_n(hi_b, 0);
    run(8'hb1, 8'h01, 8'h40, 8'h40, 510);
    chk_n(hi_a, 128);
    chk_n(hi_b, 382);
    run(8'h51, 8'h01, 8'h40, 8'h40, 510);
    chk_n(ch_a, 0);
    chk_n(ch_b, 0);
    run(8'hb1, 8'h09, 8'h80, 8'h80, 510);
    chk_n(hi_a, 510);
    chk_n(hi_b, 0);
    run(8'h50, 8'h09, 8'h02, 8'h05, 256);
    chk_n(ch_a, 1);
    chk_n(ch_b, 1);
    $display("test wave done");
  endtask

  // Prints the counts and the verdict, then ends the run
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge mclk_in);
    nrst_in <= 1'b1;
    t_regs();
    t_presc();
    t_async();
    t_flag();
    t_wave();
    results();
  end
endmodule
